// ===== rtl/flash_seq_pkg.sv
// Shared constants for the serial flash command sequencer
package flash_seq_pkg;

  // Clock and timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_W_NS_DEFAULT = 1000000;

  // Command opcodes
  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS   = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS  = 8'h01;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_FAST_READ     = 8'h0B;

  // Status byte layout
  localparam int SR_WIP  = 0;
  localparam int SR_WEL  = 1;
  localparam int SR_BP_LO = 2;
  localparam int SR_BP_HI = 4;
  localparam int SR_SWD  = 7;
  localparam logic [7:0] SR_WRITE_MASK = 8'h9C;

  // Reset values
  localparam logic [2:0] BP_RESET  = 3'h0;
  localparam logic       SWD_RESET = 1'b0;

  // Address space
  localparam int ADDR_W = 24;
  localparam logic [ADDR_W:0] ADDR_SPAN = 25'h1000000;

  // APB register byte offsets
  localparam logic [7:0] REG_STATUS     = 8'h00;
  localparam logic [7:0] REG_MEM_ADDR   = 8'h04;
  localparam logic [7:0] REG_MEM_DATA   = 8'h08;
  localparam logic [7:0] REG_PROT_QUERY = 8'h0C;

  // Command phases
  typedef enum logic [3:0] {
    PH_IDLE   = 4'b0000,
    PH_OPCODE = 4'b0001,
    PH_ADDR   = 4'b0010,
    PH_DUMMY  = 4'b0011,
    PH_DATA   = 4'b0100,
    PH_STAT   = 4'b0101,
    PH_WSR    = 4'b0110,
    PH_WSR_OK = 4'b0111,
    PH_WREN   = 4'b1000,
    PH_WRDI   = 4'b1001,
    PH_IGNORE = 4'b1010
  } phase_t;

endpackage

// ===== rtl/flash_seq.sv
// Serial flash status-write, protection and read sequencer with APB access
// What this block does
// - Status write needs write enable latch set
// - Status write keeps bits 6,5,1,0 unchanged
// - Status bits 6 and 5 read zero
// - Select must rise right after data byte
// - Select rise starts timed cycle, busy set
// - Status reads answered during timed cycle
// - Cycle end clears write enable latch
// - Status write sets three protect level bits
// - Status write sets or clears write disable
// - Hardware mode: pin low and disable set
// - Hardware mode refuses every status write
// - Disable clear: writes allowed with latch set
// - Protected areas refuse program and erase; this block has neither command, only the protection query register
// - Hardware mode entered by whichever comes last
// - Only pin high leaves hardware mode
// - Read: opcode, three address bytes, edges
// - Address increments per byte and wraps
// - Select high stops data drive at once
// - Read refused while cycle in progress
// - Fast read adds one dummy byte
// - Busy bit set during any timed cycle
// - Latch clear refuses writes
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/10ps
`default_nettype none

module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int T_W_NS = T_W_NS_DEFAULT,
  parameter int MEM_AW = 8
) (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  // Serial link pins
  input  wire logic        i_select_n,
  input  wire logic        i_serial_clock,
  input  wire logic        i_serial_in_line,
  input  wire logic        i_write_protect_pin_n,
  output logic             o_serial_out_line,
  output logic             o_serial_out_oe,
  // Status outputs
  output logic             o_write_in_progress,
  output logic             o_write_enable_latch,
  output logic             o_hardware_protected_mode,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr
);

  localparam int TW_CYC_RAW = T_W_NS / CLK_PERIOD_NS;
  localparam int TW_CYC = (TW_CYC_RAW < 1) ? 1 : TW_CYC_RAW;

  typedef struct packed {
    logic [2:0]        cs_sync;
    logic [2:0]        sck_sync;
    logic [2:0]        din_sync;
    logic [2:0]        wp_sync;
    logic              cs_lvl;
    logic              sck_lvl;
    logic              wp_lvl;
    phase_t            phase;
    logic              fast;
    logic [2:0]        bitcnt;
    logic [1:0]        bytecnt;
    logic [7:0]        shreg;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        out_sh;
    logic              dout;
    logic              doe;
    logic              write_enable_latch;
    logic              write_in_progress;
    logic [2:0]        bp;
    logic              swd;
    logic              hardware_protected_mode;
    logic [7:0]        pend;
    logic [31:0]       timer;
    logic [MEM_AW-1:0] mem_ptr;
    logic [ADDR_W-1:0] query;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } state_t;

  state_t st_ff;
  state_t nxt_st;

  logic [7:0] mem [0:(1<<MEM_AW)-1];

  logic              cs_new;
  logic              sck_new;
  logic              din_new;
  logic              sck_rise;
  logic              sck_fall;
  logic              cs_rise;
  logic              cs_fall;
  logic [7:0]        byte_in;
  logic [7:0]        status_byte;
  logic              apb_setup;
  logic              apb_write;
  logic              query_prot;

  // Program and sector erase may not touch a protected address; here this only answers the protection query register
  function automatic logic is_protected(input logic [2:0] bp,
                                        input logic [ADDR_W-1:0] a);
    logic [ADDR_W:0] size;
    size = ADDR_SPAN >> (3'h7 - bp);
    if (bp == 3'h0) begin
      is_protected = 1'b0;
    end else begin
      is_protected = ({1'b0, a} >= (ADDR_SPAN - size));
    end
  endfunction

  always_comb begin
    // A level counts once second and third stages agree
    cs_new  = (st_ff.cs_sync[1] == st_ff.cs_sync[2]) ?
              st_ff.cs_sync[2] : st_ff.cs_lvl;
    sck_new = (st_ff.sck_sync[1] == st_ff.sck_sync[2]) ?
              st_ff.sck_sync[2] : st_ff.sck_lvl;
    din_new = st_ff.din_sync[2];
    cs_rise  = cs_new & ~st_ff.cs_lvl;
    cs_fall  = ~cs_new & st_ff.cs_lvl;
    sck_rise = sck_new & ~st_ff.sck_lvl & ~cs_new;
    sck_fall = ~sck_new & st_ff.sck_lvl & ~cs_new;
    byte_in  = {st_ff.shreg[6:0], din_new};
    status_byte = 8'h00;
    status_byte[SR_WIP] = st_ff.write_in_progress;
    status_byte[SR_WEL] = st_ff.write_enable_latch;
    status_byte[SR_BP_HI:SR_BP_LO] = st_ff.bp;
    status_byte[SR_SWD] = st_ff.swd;
    query_prot = is_protected(st_ff.bp, st_ff.query);
    apb_setup = i_psel & ~i_penable;
    apb_write = i_psel & i_penable & st_ff.pready & i_pwrite;

    nxt_st = st_ff;
    nxt_st.cs_sync  = {st_ff.cs_sync[1:0], i_select_n};
    nxt_st.sck_sync = {st_ff.sck_sync[1:0], i_serial_clock};
    nxt_st.din_sync = {st_ff.din_sync[1:0], i_serial_in_line};
    nxt_st.wp_sync  = {st_ff.wp_sync[1:0], i_write_protect_pin_n};
    nxt_st.cs_lvl  = cs_new;
    nxt_st.sck_lvl = sck_new;
    if (st_ff.wp_sync[1] == st_ff.wp_sync[2]) begin
      nxt_st.wp_lvl = st_ff.wp_sync[2];
    end
    // Follows pin and bit live, so order of events is irrelevant
    nxt_st.hardware_protected_mode = ~nxt_st.wp_lvl & st_ff.swd;

    // Self-timed status write cycle
    if (st_ff.write_in_progress) begin
      nxt_st.timer = st_ff.timer - 32'h1;
      if (st_ff.timer <= 32'h1) begin
        nxt_st.write_in_progress = 1'b0;
        nxt_st.write_enable_latch = 1'b0;
      end
    end

    if (cs_fall) begin
      nxt_st.phase  = PH_OPCODE;
      nxt_st.bitcnt = 3'h0;
    end else if (cs_rise) begin
      // Anything not on a byte boundary is dropped
      if (st_ff.bitcnt == 3'h0) begin
        case (st_ff.phase)
          PH_WSR_OK: begin
            nxt_st.swd   = st_ff.pend[SR_SWD];
            nxt_st.bp    = st_ff.pend[SR_BP_HI:SR_BP_LO];
            nxt_st.write_in_progress   = 1'b1;
            nxt_st.timer = 32'(TW_CYC);
          end
          PH_WREN: begin
            nxt_st.write_enable_latch = 1'b1;
          end
          PH_WRDI: begin
            nxt_st.write_enable_latch = 1'b0;
          end
          default: begin
          end
        endcase
      end
      nxt_st.phase = PH_IDLE;
      nxt_st.doe   = 1'b0;
      nxt_st.dout  = 1'b0;
    end else if (sck_rise) begin
      nxt_st.shreg  = byte_in;
      // Output phases count bits on falling edges only
      if (st_ff.phase != PH_DATA && st_ff.phase != PH_STAT) begin
        nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
      end
      case (st_ff.phase)
        PH_OPCODE: begin
          if (st_ff.bitcnt == 3'h7) begin
            nxt_st.bytecnt = 2'h0;
            case (byte_in)
              OP_WRITE_ENABLE: begin
                nxt_st.phase = st_ff.write_in_progress ? PH_IGNORE : PH_WREN;
              end
              OP_WRITE_DISABLE: begin
                nxt_st.phase = st_ff.write_in_progress ? PH_IGNORE : PH_WRDI;
              end
              OP_READ_STATUS: begin
                nxt_st.phase = PH_STAT;
              end
              OP_WRITE_STATUS: begin
                // Refused without latch, in hardware mode or when busy
                nxt_st.phase = (st_ff.write_enable_latch && !st_ff.hardware_protected_mode && !st_ff.write_in_progress) ?
                               PH_WSR : PH_IGNORE;
              end
              OP_READ, OP_FAST_READ: begin
                nxt_st.phase = st_ff.write_in_progress ? PH_IGNORE : PH_ADDR;
                nxt_st.fast  = (byte_in == OP_FAST_READ);
              end
              default: begin
                nxt_st.phase = PH_IGNORE;
              end
            endcase
          end
        end
        PH_ADDR: begin
          if (st_ff.bitcnt == 3'h7) begin
            nxt_st.addr = {st_ff.addr[ADDR_W-9:0], byte_in};
            nxt_st.bytecnt = st_ff.bytecnt + 2'h1;
            if (st_ff.bytecnt == 2'h2) begin
              nxt_st.phase = st_ff.fast ? PH_DUMMY : PH_DATA;
            end
          end
        end
        PH_DUMMY: begin
          if (st_ff.bitcnt == 3'h7) begin
            nxt_st.phase = PH_DATA;
          end
        end
        PH_WSR: begin
          if (st_ff.bitcnt == 3'h7) begin
            nxt_st.pend  = byte_in;
            nxt_st.phase = PH_WSR_OK;
          end
        end
        PH_WSR_OK, PH_WREN, PH_WRDI: begin
          // Extra clocks past the last byte cancel the command
          nxt_st.phase = PH_IGNORE;
        end
        default: begin
        end
      endcase
    end else if (sck_fall &&
                 (st_ff.phase == PH_DATA || st_ff.phase == PH_STAT)) begin
      nxt_st.doe = 1'b1;
      if (st_ff.bitcnt == 3'h0) begin
        if (st_ff.phase == PH_DATA) begin
          nxt_st.dout   = mem[st_ff.addr[MEM_AW-1:0]][7];
          nxt_st.out_sh = {mem[st_ff.addr[MEM_AW-1:0]][6:0], 1'b0};
          nxt_st.addr   = st_ff.addr + 24'h1;
        end else begin
          nxt_st.dout   = status_byte[7];
          nxt_st.out_sh = {status_byte[6:0], 1'b0};
        end
      end else begin
        nxt_st.dout   = st_ff.out_sh[7];
        nxt_st.out_sh = {st_ff.out_sh[6:0], 1'b0};
      end
      nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
    end

    // APB: answer prepared in setup, given in access with no wait
    nxt_st.pready  = apb_setup;
    nxt_st.pslverr = 1'b0;
    if (apb_setup) begin
      nxt_st.prdata = 32'h0;
      if (i_paddr == REG_STATUS) begin
        nxt_st.prdata = {22'h0, st_ff.hardware_protected_mode, st_ff.write_in_progress, status_byte};
      end else if (i_paddr == REG_MEM_ADDR) begin
        nxt_st.prdata = {{(32-MEM_AW){1'b0}}, st_ff.mem_ptr};
      end else if (i_paddr == REG_MEM_DATA) begin
        nxt_st.prdata = {24'h0, mem[st_ff.mem_ptr]};
      end else if (i_paddr == REG_PROT_QUERY) begin
        nxt_st.prdata = {6'h0, st_ff.query,
                         (st_ff.bp != 3'h0), query_prot};
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end
    if (apb_write) begin
      if (i_paddr == REG_MEM_ADDR) begin
        nxt_st.mem_ptr = i_pwdata[MEM_AW-1:0];
      end else if (i_paddr == REG_MEM_DATA) begin
        nxt_st.mem_ptr = st_ff.mem_ptr + 1'b1;
      end else if (i_paddr == REG_PROT_QUERY) begin
        nxt_st.query = i_pwdata[ADDR_W+1:2];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_ff         <= '0;
      st_ff.cs_sync <= 3'h7;
      st_ff.cs_lvl  <= 1'b1;
      st_ff.wp_sync <= 3'h7;
      st_ff.wp_lvl  <= 1'b1;
      st_ff.phase   <= PH_IDLE;
      st_ff.bp      <= BP_RESET;
      st_ff.swd     <= SWD_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Memory content is loaded by software, one byte per data access
  always_ff @(posedge i_clk) begin
    if (apb_write && i_paddr == REG_MEM_DATA) begin
      mem[st_ff.mem_ptr] <= i_pwdata[7:0];
    end
  end

  assign o_serial_out_line         = st_ff.dout;
  assign o_serial_out_oe           = st_ff.doe;
  assign o_write_in_progress       = st_ff.write_in_progress;
  assign o_write_enable_latch      = st_ff.write_enable_latch;
  assign o_hardware_protected_mode = st_ff.hardware_protected_mode;
  assign o_prdata                  = st_ff.prdata;
  assign o_pready                  = st_ff.pready;
  assign o_pslverr                 = st_ff.pslverr;

endmodule

`default_nettype wire

// ===== testbench/flash_seq_monitor.sv
// Port checker for the flash sequencer
`timescale 1ns/10ps
`default_nettype none
module flash_seq_monitor
  import flash_seq_pkg::*;
(
  // Clock, reset, pins
  input wire logic        i_clk,
  input wire logic        i_reset_n,
  input wire logic        i_select_n,
  input wire logic        i_write_protect_pin_n,
  // Register bus
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  // Status and link outputs
  input wire logic        o_serial_out_oe,
  input wire logic        o_write_in_progress,
  input wire logic        o_write_enable_latch,
  input wire logic        o_hardware_protected_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  property p_wel_first;
    $rose(o_write_in_progress) |-> $past(o_write_enable_latch);
  endproperty
  a_wel_first: assert property (p_wel_first)
    else $error("cycle without latch");
  property p_hpm_block;
    $rose(o_write_in_progress) |-> !$past(o_hardware_protected_mode);
  endproperty
  a_hpm_block: assert property (p_hpm_block)
    else $error("write ran in hardware mode");
  property p_busy_hold;
    $rose(o_write_in_progress) |=> o_write_in_progress [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");
  property p_wel_clear;
    $fell(o_write_in_progress) |-> ##[0:2] !o_write_enable_latch;
  endproperty
  a_wel_clear: assert property (p_wel_clear)
    else $error("latch kept after cycle");
  property p_hpm_rise;
    $rose(o_hardware_protected_mode) |-> !i_write_protect_pin_n;
  endproperty
  a_hpm_rise: assert property (p_hpm_rise)
    else $error("hardware mode with pin high");
  property p_hpm_exit;
    i_write_protect_pin_n [*8] |-> !o_hardware_protected_mode;
  endproperty
  a_hpm_exit: assert property (p_hpm_exit)
    else $error("hardware mode kept");
  property p_oe_off;
    i_select_n [*6] |-> !o_serial_out_oe;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data driven while deselected");
  property p_rd_zero;
    o_pready && !i_pwrite && i_paddr == REG_STATUS |-> o_prdata[6:5] == 2'h0;
  endproperty
  a_rd_zero: assert property (p_rd_zero)
    else $error("status bits 6:5 not zero");
  c_busy: cover property ($rose(o_write_in_progress));
  c_hpm: cover property ($rose(o_hardware_protected_mode));
  c_oe: cover property ($rose(o_serial_out_oe));
endmodule
`default_nettype wire

// ===== testbench/spi_host_model.sv
// Behavioural SPI host for the flash link
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
  // Link lines
  output logic      o_select_n,
  output logic      o_serial_clock,
  output logic      o_serial_in_line,
  input wire logic  i_serial_out_line
);
  initial begin
    o_select_n = 1'b1;
    o_serial_clock = 1'b0;
    o_serial_in_line = 1'b0;
  end
  // Long gaps leave room for the pin synchronisers
  task sel(input logic lvl);
    #1700 o_select_n = lvl;
    #1700;
  endtask
  // Mode 0, MSB first; clock idles low outside frames
  task shift(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      o_serial_in_line = b[i];
      #400 o_serial_clock = 1'b1;
      #390 r[i] = i_serial_out_line;
      #10 o_serial_clock = 1'b0;
    end
    o_serial_in_line = ~b[0];
  endtask
endmodule
`default_nettype wire

// ===== testbench/spi_flash_status_write_and_read_tb.sv
// Self-checking bench for status write, protection and reads
`timescale 1ns/10ps
`default_nettype none
module spi_flash_status_write_and_read_tb;
  import flash_seq_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        i_write_protect_pin_n = 1'b1;
  logic        i_psel = 1'b0;
  logic        i_penable = 1'b0;
  logic        i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00;
  logic [31:0] i_pwdata = 32'h0;
  logic        i_select_n, i_serial_clock, i_serial_in_line;
  logic        o_serial_out_line, o_serial_out_oe, o_pready, o_pslverr;
  logic        o_write_in_progress, o_write_enable_latch;
  logic        o_hardware_protected_mode, e;
  logic [31:0] o_prdata, r;
  logic [7:0]  rx;
  int          miscompares = 0;
  int          total_checks = 0;
  // Pull-up on the data line while the block does not drive it
  wire         sdo_w = o_serial_out_oe ? o_serial_out_line : 1'b1;
  flash_seq #(.T_W_NS(60000), .MEM_AW(8)) flash_seq_inst (
    .i_clk, .i_reset_n, .i_select_n, .i_serial_clock, .i_serial_in_line,
    .i_write_protect_pin_n, .o_serial_out_line, .o_serial_out_oe,
    .o_write_in_progress, .o_write_enable_latch, .o_hardware_protected_mode,
    .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr);
  spi_host_model spi_host_model_inst (.o_select_n(i_select_n),
    .o_serial_clock(i_serial_clock), .o_serial_in_line(i_serial_in_line),
    .i_serial_out_line(sdo_w));
  always #50 i_clk = ~i_clk;
  task check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    r = o_prdata;
    e = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task cs(input logic l);
    spi_host_model_inst.sel(l);
  endtask
  task xb(input logic [7:0] b);
    spi_host_model_inst.shift(b, rx);
  endtask
  task wren;
    cs(1'b0);
    xb(OP_WRITE_ENABLE);
    cs(1'b1);
  endtask
  task wrsr(input logic [7:0] d);
    cs(1'b0);
    xb(OP_WRITE_STATUS);
    xb(d);
    cs(1'b1);
  endtask
  task settle;
    for (int i = 0; i < 900 && o_write_in_progress !== 1'b0; i++)
      @(negedge i_clk);
    if (o_write_in_progress !== 1'b0) begin
      miscompares++;
      $display("[FAIL] %0t busy never cleared", $time);
    end
  endtask
  task stat(input logic [7:0] x);
    apb(1'b0, REG_STATUS, 32'h0);
    check(r[7:0], x);
  endtask
  // Pin settles through the synchroniser before we look
  task pin(input logic l);
    @(posedge i_clk);
    i_write_protect_pin_n <= l;
    repeat (10) @(posedge i_clk);
  endtask
  task t_basic;
    stat(8'h00);
    apb(1'b0, 8'h10, 32'h0);
    check(8'(e), 8'h1);
    wrsr(8'h9C);
    settle();
    stat(8'h00);
    $display("basic done");
  endtask
  task t_prot;
    wren();
    wrsr(8'hFF);
    cs(1'b0);
    xb(OP_READ_STATUS);
    xb(8'h00);
    cs(1'b1);
    check(rx & 8'h63, 8'h03);
    settle();
    stat(8'h9C);
    check(8'(o_hardware_protected_mode), 8'h0);
    pin(1'b0);
    check(8'(o_hardware_protected_mode), 8'h1);
    wren();
    wrsr(8'h00);
    settle();
    stat(8'h9E);
    pin(1'b1);
    check(8'(o_hardware_protected_mode), 8'h0);
    wrsr(8'h00);
    settle();
    stat(8'h00);
    pin(1'b0);
    wren();
    wrsr(8'h80);
    settle();
    stat(8'h80);
    check(8'(o_hardware_protected_mode), 8'h1);
    pin(1'b1);
    $display("protect done");
  endtask
  task t_abort;
    wren();
    cs(1'b0);
    xb(OP_WRITE_STATUS);
    xb(8'h1C);
    xb(8'h00);
    cs(1'b1);
    settle();
    stat(8'h82);
    cs(1'b0);
    xb(OP_WRITE_STATUS);
    cs(1'b1);
    settle();
    stat(8'h82);
    wren();
    cs(1'b0);
    xb(OP_WRITE_DISABLE);
    cs(1'b1);
    wrsr(8'h00);
    settle();
    stat(8'h80);
    $display("abort done");
  endtask
  task t_read;
    logic [7:0] want [3];
    want = '{8'hA5, 8'h5A, 8'hC3};
    apb(1'b1, REG_MEM_ADDR, 32'hFE);
    apb(1'b1, REG_MEM_DATA, 32'hA5);
    apb(1'b1, REG_MEM_DATA, 32'h5A);
    apb(1'b1, REG_MEM_ADDR, 32'h0);
    apb(1'b1, REG_MEM_DATA, 32'hC3);
    apb(1'b0, REG_MEM_ADDR, 32'h0);
    check(r[7:0], 8'h01);
    for (int k = 0; k < 2; k++) begin
      cs(1'b0);
      xb(k == 0 ? OP_READ : OP_FAST_READ);
      xb(8'hFF);
      xb(8'hFF);
      xb(8'hFE);
      if (k == 1) xb(8'h00);
      for (int j = 0; j < 3; j++) begin
        xb(8'h00);
        check(rx, want[j]);
      end
      cs(1'b1);
      check(8'(o_serial_out_oe), 8'h0);
    end
    $display("read done");
  endtask
  task t_busy;
    wren();
    wrsr(8'h80);
    cs(1'b0);
    xb(OP_READ);
    repeat (4) xb(8'h00);
    check(rx, 8'hFF);
    check(8'(o_serial_out_oe), 8'h0);
    check(8'(o_write_in_progress), 8'h1);
    cs(1'b1);
    settle();
    stat(8'h80);
    $display("busy done");
  endtask
  // Level 1 protects the top 2^24 >> 6 bytes
  task t_query;
    wren();
    wrsr(8'h04);
    settle();
    stat(8'h04);
    apb(1'b1, REG_PROT_QUERY, 32'h03F00000);
    apb(1'b0, REG_PROT_QUERY, 32'h0);
    check(r[7:0], 8'h03);
    apb(1'b1, REG_PROT_QUERY, 32'h03EFFFFC);
    apb(1'b0, REG_PROT_QUERY, 32'h0);
    check(r[7:0], 8'hFE);
    $display("query done");
  endtask
  task stop_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    t_basic();
    t_prot();
    t_abort();
    t_read();
    t_busy();
    t_query();
    stop_test();
  end
  initial begin
    #3000000;
    miscompares++;
    $display("[FAIL] %0t watchdog expired", $time);
    stop_test();
  end
endmodule
bind flash_seq flash_seq_monitor flash_seq_monitor_inst (.i_clk, .i_reset_n,
  .i_select_n, .i_write_protect_pin_n, .i_pwrite, .i_paddr, .o_prdata,
  .o_pready, .o_serial_out_oe, .o_write_in_progress, .o_write_enable_latch,
  .o_hardware_protected_mode);
`default_nettype wire
